/* File: logic/core_config_and_fetch_timing.sv */
// Start-up option loader, two-phase fetch sequencer and clock mode control.
`timescale 1ns/1ps
module core_config_and_fetch_timing
(
  input wire logic clk,
  input wire logic reset,
  // Software register port.
  input wire logic [core_cfg_pkg::REG_AW-1:0] reg_addr,
  input wire logic [core_cfg_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [core_cfg_pkg::REG_DW-1:0] reg_rdata,
  // Program ROM fetch port.
  output logic [core_cfg_pkg::ROM_AW-1:0] rom_addr,
  input wire logic [core_cfg_pkg::OPT_W-1:0] rom_data,
  // Execute stage hand-off and redirects.
  output logic [core_cfg_pkg::OPT_W-1:0] exec_word,
  output logic exec_valid,
  output logic phase_one,
  output logic phase_two,
  input wire logic branch_req,
  input wire logic [core_cfg_pkg::ROM_AW-1:0] branch_target,
  input wire logic irq_take,
  // External programmer read-back port.
  input wire logic prog_rd,
  input wire logic [core_cfg_pkg::ROM_AW-1:0] prog_addr,
  input wire logic [core_cfg_pkg::OPT_W-1:0] prog_rom_data,
  output logic [core_cfg_pkg::OPT_W-1:0] prog_rdata,
  output logic prog_denied,
  // Pins and reset sources.
  input wire logic ext_reset_n,
  output logic pin_input_level,
  input wire logic wdt_timeout,
  input wire logic volt_below_low,
  input wire logic volt_below_high,
  input wire logic wake_event,
  output logic sys_reset_req,
  // Oscillator and clock controls.
  output logic fast_osc_enable,
  output logic slow_osc_enable,
  output logic [1:0] fast_osc_freq_sel,
  output logic core_clock_select,
  output logic core_clock_run,
  output logic wake_timer_enable
);

  // Sequencer state and fetch pipeline.
  core_cfg_pkg::seq_t state_ff;
  logic [core_cfg_pkg::OPT_W-1:0] startup_option_word_ff; // Captured word.
  logic [core_cfg_pkg::ROM_AW-1:0] pc_ff; // Doubles as the ROM address.
  logic phase_ff; // Low in phase one, high in phase two.
  logic [core_cfg_pkg::OPT_W-1:0] ir_ff; // Word latched in phase two.
  logic ir_valid_ff; // Cleared when the fetched word is flushed.
  logic [core_cfg_pkg::OPT_W-1:0] exec_word_ff; // Word under execution.
  logic exec_valid_ff;
  logic redirect_ff; // A branch or interrupt target is waiting.
  logic [core_cfg_pkg::ROM_AW-1:0] target_ff;
  // Control registers and status.
  logic [core_cfg_pkg::CK_W-1:0] clk_ctrl_ff;
  logic stop_req_ff; // Software asked for stop; cleared on entry.
  logic [1:0] cause_ff;
  logic [core_cfg_pkg::REG_DW-1:0] rdata_ff;
  logic [core_cfg_pkg::OPT_W-1:0] prog_rdata_ff;
  logic prog_denied_ff;
  // Pin synchronisers.
  logic pin_meta_ff, pin_sync_ff, pin_prev_ff;
  logic low_meta_ff, low_sync_ff;
  logic high_meta_ff, high_sync_ff;
  logic wake_meta_ff, wake_sync_ff, wake_prev_ff;
  logic sys_reset_req_ff;
  // Combinational helpers.
  logic [core_cfg_pkg::ROM_AW-1:0] vec_base;
  logic [core_cfg_pkg::ROM_AW-1:0] nxt_pc;
  logic pin_fall;
  logic wdt_hit;
  logic bor_trip;
  logic prog_guard;

  cfg_opt_if opt ();

  // Options are decoded from the captured word; only the reset vector reads the re-use bit from the bus.
  cfg_decode u_decode
  (
    .startup_option_word(startup_option_word_ff),
    .opt(opt)
  );

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------

  // Asynchronous levels pass two flops before any logic reads them.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
      pin_prev_ff <= 1'b1;
      low_meta_ff <= 1'b0;
      low_sync_ff <= 1'b0;
      high_meta_ff <= 1'b0;
      high_sync_ff <= 1'b0;
      wake_meta_ff <= 1'b0;
      wake_sync_ff <= 1'b0;
      wake_prev_ff <= 1'b0;
    end
    else
    begin
      pin_meta_ff <= ext_reset_n;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
      low_meta_ff <= volt_below_low;
      low_sync_ff <= low_meta_ff;
      high_meta_ff <= volt_below_high;
      high_sync_ff <= high_meta_ff;
      wake_meta_ff <= wake_event;
      wake_sync_ff <= wake_meta_ff;
      wake_prev_ff <= wake_sync_ff;
    end
  end

  // --------------------------------------------------------------------
  // Reset sources
  // --------------------------------------------------------------------

  // Falling edge of the pin counts only while pin reset is enabled.
  assign pin_fall = pin_prev_ff & ~pin_sync_ff &
                    opt.pin_reset_enable;
  assign wdt_hit = wdt_timeout & opt.watchdog_reset_enable;

  // Brown-out mode chooses threshold and whether stop disables it.
  always_comb
  begin
    case (opt.brownout_reset_mode)
      core_cfg_pkg::BOR_LOW_ALWAYS: bor_trip = low_sync_ff;
      core_cfg_pkg::BOR_LOW_RUN:
        bor_trip = low_sync_ff & (state_ff != core_cfg_pkg::ST_STOP);
      core_cfg_pkg::BOR_HIGH_ALWAYS: bor_trip = high_sync_ff;
      default: bor_trip = 1'b0;
    endcase
  end

  // Sources are ignored until the options are known to avoid acting on
  // the unprogrammed defaults.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sys_reset_req_ff <= 1'b0;
      cause_ff <= core_cfg_pkg::CAUSE_NONE;
    end
    else if (state_ff == core_cfg_pkg::ST_RUN ||
             state_ff == core_cfg_pkg::ST_STOP)
    begin
      sys_reset_req_ff <= pin_fall | wdt_hit | bor_trip;
      // Brown-out wins the cause code as the most severe source.
      if (bor_trip)
        cause_ff <= core_cfg_pkg::CAUSE_BOR;
      else if (wdt_hit)
        cause_ff <= core_cfg_pkg::CAUSE_WDT;
      else if (pin_fall)
        cause_ff <= core_cfg_pkg::CAUSE_PIN;
    end
    else
      sys_reset_req_ff <= 1'b0;
  end

  // --------------------------------------------------------------------
  // Load sequencer and two-phase fetch
  // --------------------------------------------------------------------

  // Vectors sit at the second half in re-use operation.
  assign vec_base = opt.reuse_on ? core_cfg_pkg::HALF_BASE
                                 : core_cfg_pkg::VEC_LOW;
  assign nxt_pc = redirect_ff ? target_ff
                              : pc_ff + core_cfg_pkg::PC_STEP;

  // The sequencer reads the option word, then alternates the phases.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= core_cfg_pkg::ST_LOAD;
      startup_option_word_ff <= core_cfg_pkg::OPT_UNPROG;
      pc_ff <= core_cfg_pkg::OPT_ADDR;
      phase_ff <= 1'b0;
    end
    else if (sys_reset_req_ff)
    begin
      // A system reset reloads the options before fetching again.
      state_ff <= core_cfg_pkg::ST_LOAD;
      pc_ff <= core_cfg_pkg::OPT_ADDR;
      phase_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        core_cfg_pkg::ST_LOAD:
        begin
          pc_ff <= core_cfg_pkg::OPT_ADDR;
          state_ff <= core_cfg_pkg::ST_CAPTURE;
        end
        core_cfg_pkg::ST_CAPTURE:
        begin
          startup_option_word_ff <= rom_data;
          // Reset vector follows the freshly read re-use bit.
          pc_ff <= rom_data[core_cfg_pkg::BIT_REUSE] ?
                   core_cfg_pkg::VEC_LOW : core_cfg_pkg::HALF_BASE;
          phase_ff <= 1'b1;
          state_ff <= core_cfg_pkg::ST_RUN;
        end
        core_cfg_pkg::ST_RUN:
        begin
          phase_ff <= ~phase_ff;
          // Stop is entered on a whole instruction boundary.
          if (phase_ff && stop_req_ff)
            state_ff <= core_cfg_pkg::ST_STOP;
          else if (!phase_ff)
            pc_ff <= nxt_pc;
        end
        core_cfg_pkg::ST_STOP:
        begin
          if (wake_sync_ff && !wake_prev_ff)
            state_ff <= core_cfg_pkg::ST_RUN;
        end
        default: state_ff <= core_cfg_pkg::ST_LOAD;
      endcase
    end
  end

  // Phase two latches the fetched word; phase one hands it to execute.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ir_ff <= '0;
      ir_valid_ff <= 1'b0;
      exec_word_ff <= '0;
      exec_valid_ff <= 1'b0;
      redirect_ff <= 1'b0;
      target_ff <= '0;
    end
    else if (state_ff != core_cfg_pkg::ST_RUN || sys_reset_req_ff)
    begin
      ir_valid_ff <= 1'b0;
      exec_valid_ff <= 1'b0;
      redirect_ff <= 1'b0;
    end
    else if (phase_ff)
    begin
      ir_ff <= rom_data;
      // A redirect discards the word fetched beside it.
      ir_valid_ff <= ~(exec_valid_ff & (branch_req | irq_take));
      if (exec_valid_ff && irq_take)
      begin
        redirect_ff <= 1'b1;
        target_ff <= vec_base + core_cfg_pkg::IRQ_OFS;
      end
      else if (exec_valid_ff && branch_req)
      begin
        redirect_ff <= 1'b1;
        target_ff <= branch_target;
      end
    end
    else
    begin
      exec_word_ff <= ir_ff;
      exec_valid_ff <= ir_valid_ff;
      redirect_ff <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Programmer read-back protection
  // --------------------------------------------------------------------

  // With re-use bit set only the first half is guarded, so the second
  // half can be written and verified; otherwise all but the reserved
  // tail is hidden.
  assign prog_guard = opt.protect_on &&
    (startup_option_word_ff[core_cfg_pkg::BIT_REUSE] ?
     (prog_addr < core_cfg_pkg::HALF_BASE) :
     (prog_addr < core_cfg_pkg::RESV_BASE));

  // Guarded reads return zeros and raise the denial flag.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      prog_rdata_ff <= '0;
      prog_denied_ff <= 1'b0;
    end
    else if (prog_rd)
    begin
      prog_rdata_ff <= prog_guard ? '0 : prog_rom_data;
      prog_denied_ff <= prog_guard;
    end
  end

  // --------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------

  // Clock control writes; the stop request self-clears on stop entry.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      clk_ctrl_ff <= core_cfg_pkg::CK_RST;
      stop_req_ff <= 1'b0;
    end
    else if (sys_reset_req_ff)
    begin
      clk_ctrl_ff <= core_cfg_pkg::CK_RST;
      stop_req_ff <= 1'b0;
    end
    else if (reg_wr && reg_addr == core_cfg_pkg::ADDR_CLK_CTRL)
    begin
      clk_ctrl_ff <= reg_wdata[core_cfg_pkg::CK_W-1:0];
      stop_req_ff <= reg_wdata[core_cfg_pkg::CK_STOP];
    end
    else if (state_ff == core_cfg_pkg::ST_STOP)
      stop_req_ff <= 1'b0;
  end

  // Read data stands one cycle after the strobe; unmapped reads zero.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdata_ff <= '0;
    else if (reg_rd)
    begin
      case (reg_addr)
        core_cfg_pkg::ADDR_CLK_CTRL:
          rdata_ff <= {{(core_cfg_pkg::REG_DW-core_cfg_pkg::CK_W){1'b0}},
                       clk_ctrl_ff[core_cfg_pkg::CK_W-1:
                                   core_cfg_pkg::CK_STOP+1],
                       stop_req_ff,
                       clk_ctrl_ff[core_cfg_pkg::CK_STOP-1:0]};
        core_cfg_pkg::ADDR_OPTION:
          rdata_ff <= {2'h0, startup_option_word_ff};
        core_cfg_pkg::ADDR_STATUS:
          rdata_ff <= {10'h000, cause_ff,
                       (state_ff == core_cfg_pkg::ST_STOP),
                       (state_ff == core_cfg_pkg::ST_RUN),
                       opt.reuse_on, opt.protect_on};
        default: rdata_ff <= '0;
      endcase
    end
    else
      rdata_ff <= '0;
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------

  assign reg_rdata = rdata_ff;
  assign rom_addr = pc_ff;
  assign exec_word = exec_word_ff;
  assign exec_valid = exec_valid_ff;
  assign phase_one = (state_ff == core_cfg_pkg::ST_RUN) & ~phase_ff;
  assign phase_two = (state_ff == core_cfg_pkg::ST_RUN) & phase_ff;
  assign prog_rdata = prog_rdata_ff;
  assign prog_denied = prog_denied_ff;
  assign pin_input_level = pin_sync_ff & ~opt.pin_reset_enable;
  assign sys_reset_req = sys_reset_req_ff;
  assign core_clock_select = clk_ctrl_ff[core_cfg_pkg::CK_SLOW];
  assign fast_osc_freq_sel =
    clk_ctrl_ff[core_cfg_pkg::CK_FSEL_HI:core_cfg_pkg::CK_FSEL_LO];
  // Slow mode stops the fast oscillator; stop halts both.
  assign fast_osc_enable = ~clk_ctrl_ff[core_cfg_pkg::CK_SLOW] &
                           (state_ff != core_cfg_pkg::ST_STOP);
  assign slow_osc_enable = (clk_ctrl_ff[core_cfg_pkg::CK_SLOW] |
                            clk_ctrl_ff[core_cfg_pkg::CK_SLOW_KEEP]) &
                           (state_ff != core_cfg_pkg::ST_STOP);
  assign core_clock_run = (state_ff != core_cfg_pkg::ST_STOP);
  assign wake_timer_enable = clk_ctrl_ff[core_cfg_pkg::CK_WKT];

endmodule

/* File: logic/core_cfg_pkg.sv */
// Shared constants and types for start-up option loading and fetch timing.
package core_cfg_pkg;

  // Option word and program memory geometry.
  localparam int OPT_W = 14;
  localparam int ROM_AW = 10;
  localparam logic [ROM_AW-1:0] OPT_ADDR = 10'h3FC;
  localparam logic [ROM_AW-1:0] HALF_BASE = 10'h200;
  localparam logic [ROM_AW-1:0] RESV_BASE = 10'h3FC;
  localparam logic [ROM_AW-1:0] VEC_LOW = 10'h000;
  localparam logic [ROM_AW-1:0] IRQ_OFS = 10'h001;
  localparam logic [ROM_AW-1:0] PC_STEP = 10'h001;
  localparam logic [OPT_W-1:0] OPT_UNPROG = 14'h3FE0;

  // Option word bit positions.
  localparam int BIT_PROTECT = 13;
  localparam int BIT_REUSE = 12;
  localparam int BOR_HI = 11;
  localparam int BOR_LO = 10;
  localparam int BIT_PIN_RST = 7;
  localparam int BIT_WDT = 6;

  // Brown-out reset mode encodings.
  localparam logic [1:0] BOR_LOW_ALWAYS = 2'h3;
  localparam logic [1:0] BOR_LOW_RUN = 2'h2;
  localparam logic [1:0] BOR_HIGH_ALWAYS = 2'h1;

  // Register port geometry and map.
  localparam int REG_AW = 4;
  localparam int REG_DW = 16;
  localparam logic [REG_AW-1:0] ADDR_CLK_CTRL = 4'h0;
  localparam logic [REG_AW-1:0] ADDR_OPTION = 4'h1;
  localparam logic [REG_AW-1:0] ADDR_STATUS = 4'h2;

  // Clock control register fields.
  localparam int CK_W = 6;
  localparam int CK_SLOW = 0;
  localparam int CK_FSEL_LO = 1;
  localparam int CK_FSEL_HI = 2;
  localparam int CK_STOP = 3;
  localparam int CK_WKT = 4;
  localparam int CK_SLOW_KEEP = 5;
  localparam logic [CK_W-1:0] CK_RST = 6'h00;

  // Reset cause codes shown in the status register.
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_PIN = 2'h1;
  localparam logic [1:0] CAUSE_WDT = 2'h2;
  localparam logic [1:0] CAUSE_BOR = 2'h3;

  // Sequencer states.
  typedef enum logic [1:0] {ST_LOAD, ST_CAPTURE, ST_RUN, ST_STOP} seq_t;

endpackage

/* File: logic/cfg_opt_if.sv */
// Decoded start-up options passed from the decoder to the sequencer.
`timescale 1ns/1ps
interface cfg_opt_if;
  logic protect_on;
  logic reuse_on;
  logic [1:0] brownout_reset_mode;
  logic pin_reset_enable;
  logic watchdog_reset_enable;

  modport decoder
  (
    output protect_on,
    output reuse_on,
    output brownout_reset_mode,
    output pin_reset_enable,
    output watchdog_reset_enable
  );
  modport user
  (
    input protect_on,
    input reuse_on,
    input brownout_reset_mode,
    input pin_reset_enable,
    input watchdog_reset_enable
  );
endinterface

/* File: logic/cfg_decode.sv */
// Decoder from the stored start-up option word to individual options.
`timescale 1ns/1ps
module cfg_decode
(
  input wire logic [core_cfg_pkg::OPT_W-1:0] startup_option_word,
  cfg_opt_if.decoder opt
);

  // Protection and re-use are active when their bits are cleared.
  assign opt.protect_on =
    ~startup_option_word[core_cfg_pkg::BIT_PROTECT];
  assign opt.reuse_on = ~startup_option_word[core_cfg_pkg::BIT_REUSE];
  // Two-bit brown-out mode is passed whole and interpreted by the user.
  assign opt.brownout_reset_mode =
    startup_option_word[core_cfg_pkg::BOR_HI:core_cfg_pkg::BOR_LO];
  assign opt.pin_reset_enable =
    startup_option_word[core_cfg_pkg::BIT_PIN_RST];
  assign opt.watchdog_reset_enable =
    startup_option_word[core_cfg_pkg::BIT_WDT];
  // Bits 9-8 and 5-0 are deliberately left undecoded.

endmodule

/* File: dv/rom_model.sv */
// Behavioural program memory with the option word held by the programmer.
`timescale 1ns/1ps
module rom_model
(
  input wire logic [core_cfg_pkg::ROM_AW-1:0] rom_addr,
  input wire logic [core_cfg_pkg::ROM_AW-1:0] prog_addr,
  input wire logic [core_cfg_pkg::OPT_W-1:0] opt_word,
  output logic [core_cfg_pkg::OPT_W-1:0] rom_data,
  output logic [core_cfg_pkg::OPT_W-1:0] prog_rom_data
);
  // Ordinary words carry their own address, so any fetch can be traced.
  // The option word comes only from the programmer side input.
  assign rom_data = (rom_addr == core_cfg_pkg::OPT_ADDR) ? opt_word
                    : {4'hA, rom_addr};
  // The programmer port sees the same array with no delay.
  assign prog_rom_data = (prog_addr == core_cfg_pkg::OPT_ADDR) ? opt_word
                         : {4'hA, prog_addr};
endmodule

/* File: dv/fetch_checker.sv */
// Concurrent checks on fetch timing and oscillator mode outputs.
`timescale 1ns/1ps
module fetch_checker
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [core_cfg_pkg::ROM_AW-1:0] rom_addr,
  input wire logic [core_cfg_pkg::OPT_W-1:0] rom_data,
  input wire logic [core_cfg_pkg::OPT_W-1:0] exec_word,
  input wire logic exec_valid,
  input wire logic phase_one,
  input wire logic phase_two,
  input wire logic branch_req,
  input wire logic [core_cfg_pkg::ROM_AW-1:0] branch_target,
  input wire logic irq_take,
  input wire logic fast_osc_enable,
  input wire logic slow_osc_enable,
  input wire logic core_clock_select,
  input wire logic core_clock_run
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // A redirect is only honoured while a valid word sits in execute.
  sequence redirect_s;
    phase_two && exec_valid && (branch_req || irq_take);
  endsequence
  // One fetch step: the address moves at the end of phase one, and the
  // phase two that follows fetches from the new address.
  sequence fetch_step_s;
    phase_one ##1 phase_two;
  endsequence
  // A plain step is a phase_two without redirect, then a fetch step.
  sequence plain_step_s;
    phase_two && !(exec_valid && (branch_req || irq_take)) ##1 fetch_step_s;
  endsequence
  AST_PHASE_EXCL:
    assert property (!(phase_one && phase_two))
      else $error("both phases high together");
  AST_PHASE_TOGGLE:
    assert property (phase_one |=> !phase_one)
      else $error("phase one lasted two clocks");
  AST_PC_STEP:
    assert property (plain_step_s |-> rom_addr == $past(rom_addr, 2) + 10'h001)
      else $error("fetch address did not step by one");
  AST_BRANCH_TARGET:
    assert property (phase_two && exec_valid && branch_req && !irq_take
      ##1 fetch_step_s |-> rom_addr == $past(branch_target, 2))
      else $error("branch did not load its target");
  AST_IRQ_VECTOR:
    assert property (phase_two && exec_valid && irq_take ##1 fetch_step_s
      |-> rom_addr[8:0] == 9'h001)
      else $error("interrupt did not go to its vector");
  AST_FLUSH:
    assert property (redirect_s |=> exec_valid ##1 !exec_valid [*2]
      ##1 exec_valid)
      else $error("redirect did not flush exactly one cycle");
  AST_LATCH_EXEC:
    assert property (phase_two ##1 fetch_step_s ##0 exec_valid
      |-> exec_word == $past(rom_data, 2))
      else $error("executed word differs from fetched word");
  AST_EXEC_HOLD:
    assert property (phase_two ##1 phase_one |-> $stable(exec_word))
      else $error("executed word changed mid cycle");
  AST_SLOW_MODE:
    assert property (core_clock_run && core_clock_select
      |-> !fast_osc_enable && slow_osc_enable)
      else $error("slow mode oscillator enables wrong");
  AST_FAST_MODE:
    assert property (core_clock_run && !core_clock_select |-> fast_osc_enable)
      else $error("fast mode without fast oscillator");
  AST_STOP_CLOCKS:
    assert property (!core_clock_run |-> !fast_osc_enable && !slow_osc_enable)
      else $error("an oscillator runs while stopped");
endmodule
bind core_config_and_fetch_timing fetch_checker fetch_checker_inst
(
  .clk(clk), .reset(reset), .rom_addr(rom_addr), .rom_data(rom_data),
  .exec_word(exec_word), .exec_valid(exec_valid), .phase_one(phase_one),
  .phase_two(phase_two), .branch_req(branch_req),
  .branch_target(branch_target), .irq_take(irq_take),
  .fast_osc_enable(fast_osc_enable), .slow_osc_enable(slow_osc_enable),
  .core_clock_select(core_clock_select), .core_clock_run(core_clock_run)
);

/* File: dv/testbench.sv */
// Self-checking bench for the option loader and fetch sequencer.
`timescale 1ns/1ps
module testbench;
  // ----
  // Stimulus and observed signals.
  // ----
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'h0, reg_rd = 1'h0, prog_rd = 1'h0;
  logic branch_req = 1'h0, irq_take = 1'h0, wake_event = 1'h0;
  logic [9:0] branch_target = 10'h000, prog_addr = 10'h000;
  logic ext_reset_n = 1'h1, wdt_timeout = 1'h0;
  logic volt_below_low = 1'h0, volt_below_high = 1'h0;
  logic [13:0] opt_word = 14'h3FF5;
  logic [15:0] reg_rdata;
  logic [9:0] rom_addr;
  logic [13:0] rom_data, exec_word, prog_rom_data, prog_rdata;
  logic exec_valid, phase_one, phase_two, prog_denied, pin_input_level;
  logic sys_reset_req, fast_osc_enable, slow_osc_enable, core_clock_select;
  logic core_clock_run, wake_timer_enable;
  logic [1:0] fast_osc_freq_sel;
  int error_cnt = 0;
  int checked = 0;
  // A 100 ns period.
  always #50 clk = ~clk;
  core_config_and_fetch_timing core_config_and_fetch_timing_inst
  (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rom_addr(rom_addr), .rom_data(rom_data), .exec_word(exec_word),
    .exec_valid(exec_valid), .phase_one(phase_one), .phase_two(phase_two),
    .branch_req(branch_req), .branch_target(branch_target),
    .irq_take(irq_take), .prog_rd(prog_rd), .prog_addr(prog_addr),
    .prog_rom_data(prog_rom_data), .prog_rdata(prog_rdata),
    .prog_denied(prog_denied), .ext_reset_n(ext_reset_n),
    .pin_input_level(pin_input_level), .wdt_timeout(wdt_timeout),
    .volt_below_low(volt_below_low), .volt_below_high(volt_below_high),
    .wake_event(wake_event), .sys_reset_req(sys_reset_req),
    .fast_osc_enable(fast_osc_enable), .slow_osc_enable(slow_osc_enable),
    .fast_osc_freq_sel(fast_osc_freq_sel),
    .core_clock_select(core_clock_select), .core_clock_run(core_clock_run),
    .wake_timer_enable(wake_timer_enable)
  );
  rom_model rom_model_inst
  (
    .rom_addr(rom_addr), .prog_addr(prog_addr), .opt_word(opt_word),
    .rom_data(rom_data), .prog_rom_data(prog_rom_data)
  );
  // ----
  // Access tasks.
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Sampling 1 ns after the edge keeps every read race free.
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    tick;
    reg_wr <= 1'h0;
    // Let an edge pass so a following call never rewrites the strobe.
    tick;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'h1;
    tick;
    reg_rd <= 1'h0;
    chk(reg_rdata, e);
    tick;
  endtask
  task automatic prd(input logic [9:0] a, input logic [15:0] d, logic dn);
    prog_addr <= a;
    prog_rd <= 1'h1;
    tick;
    prog_rd <= 1'h0;
    chk(prog_rdata, d);
    chk(prog_denied, dn);
    tick;
  endtask
  // Bounded watch: 0 reset pulse, 1 stopped, 2 running, 3 phase two with
  // no system reset pending, so a restart is never mistaken for a run.
  // A missing event that was expected ends the run at once.
  task automatic seen(input int w, input logic e);
    logic hit;
    hit = 1'h0;
    for (int i = 0; i < 12 && !hit; i++)
    begin
      case (w)
        0: hit = (sys_reset_req === 1'h1);
        1: hit = (core_clock_run === 1'h0);
        2: hit = (core_clock_run === 1'h1);
        default: hit = (phase_two === 1'h1 && sys_reset_req === 1'h0);
      endcase
      if (!hit)
        tick;
    end
    chk(hit, e);
    if (e && !hit)
      stop_test;
  endtask
  task automatic boot(input logic [13:0] w);
    opt_word <= w;
    reset <= 1'h1;
    tick;
    tick;
    reset <= 1'h0;
    seen(3, 1'h1);
  endtask
  // Redirect in a phase two with a valid word, then follow the target.
  task automatic jump(input logic b, logic i, logic [9:0] t, logic [9:0] e);
    seen(3, 1'h1);
    tick;
    seen(3, 1'h1);
    branch_req <= b;
    irq_take <= i;
    branch_target <= t;
    tick;
    branch_req <= 1'h0;
    irq_take <= 1'h0;
    // The address moves at the end of phase one, so look in phase two.
    tick;
    chk(rom_addr, e);
    chk(exec_valid, 16'h0000);
    tick;
    tick;
    chk(exec_word, {4'hA, e});
  endtask
  // ----
  // Scenarios.
  // ----
  initial
  begin
    repeat (16) tick;
    chk(rom_addr, 16'h03FC);
    reset <= 1'h0;
    seen(3, 1'h1);
    chk(rom_addr, 16'h0000);
    rd(4'h1, 16'h3FF5);
    rd(4'h2, 16'h0004);
    wr(4'h1, 16'h0000);
    rd(4'h1, 16'h3FF5);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000);
    prd(10'h010, 16'h2810, 1'h0);
    for (int f = 0; f < 4; f++)
    begin
      wr(4'h0, 16'(f * 2));
      chk(fast_osc_freq_sel, 16'(f));
    end
    wr(4'h0, 16'h0020);
    chk(slow_osc_enable, 16'h0001);
    chk(fast_osc_enable, 16'h0001);
    wr(4'h0, 16'h0001);
    chk(core_clock_select, 1'h1);
    chk(fast_osc_enable, 1'h0);
    chk(slow_osc_enable, 16'h0001);
    chk(core_clock_run, 1'h1);
    rd(4'h0, 16'h0001);
    wr(4'h0, 16'h0000);
    jump(1'h1, 1'h0, 10'h155, 10'h155);
    jump(1'h0, 1'h1, 10'h155, 10'h001);
    jump(1'h1, 1'h1, 10'h0AA, 10'h001);
    boot(14'h137F);
    rd(4'h2, 16'h0005);
    prd(10'h1FF, 16'h0000, 1'h1);
    prd(10'h200, 16'h2A00, 1'h0);
    volt_below_low <= 1'h1;
    volt_below_high <= 1'h1;
    seen(0, 1'h0);
    volt_below_low <= 1'h0;
    volt_below_high <= 1'h0;
    ext_reset_n <= 1'h0;
    seen(0, 1'h0);
    chk(pin_input_level, 1'h0);
    ext_reset_n <= 1'h1;
    seen(0, 1'h0);
    chk(pin_input_level, 1'h1);
    wdt_timeout <= 1'h1;
    tick;
    wdt_timeout <= 1'h0;
    seen(0, 1'h1);
    seen(3, 1'h1);
    rd(4'h2, 16'h0025);
    boot(14'h0C80);
    chk(rom_addr, 16'h0200);
    rd(4'h2, 16'h0007);
    prd(10'h3FB, 16'h0000, 1'h1);
    prd(10'h3FC, 16'h0C80, 1'h0);
    jump(1'h0, 1'h1, 10'h000, 10'h201);
    volt_below_high <= 1'h1;
    seen(0, 1'h0);
    volt_below_low <= 1'h1;
    seen(0, 1'h1);
    volt_below_low <= 1'h0;
    volt_below_high <= 1'h0;
    seen(3, 1'h1);
    rd(4'h2, 16'h0037);
    chk(pin_input_level, 1'h0);
    ext_reset_n <= 1'h0;
    seen(0, 1'h1);
    ext_reset_n <= 1'h1;
    seen(3, 1'h1);
    rd(4'h2, 16'h0017);
    boot(14'h2800);
    wr(4'h0, 16'h0018);
    seen(1, 1'h1);
    chk(wake_timer_enable, 1'h1);
    rd(4'h2, 16'h000A);
    volt_below_low <= 1'h1;
    seen(0, 1'h0);
    wake_event <= 1'h1;
    seen(2, 1'h1);
    wake_event <= 1'h0;
    seen(0, 1'h1);
    volt_below_low <= 1'h0;
    boot(14'h3400);
    volt_below_high <= 1'h1;
    seen(0, 1'h1);
    volt_below_high <= 1'h0;
    stop_test;
  end
endmodule
